/* verilog/rf_pwr_pkg.sv */
/*
 * Constants and carrier types shared by the RF front-end power and
 * clock controller and its two helper modules.
 * Assumes nothing of its surroundings; holds definitions only.
 */
package rf_pwr_pkg;

	// System clock and the clock figures the block is built around
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned BB_NOMINAL_KHZ = 16368;
	localparam int unsigned VCO_DIVIDE = 96;

	// Bus register byte offsets
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_PLL_N = 8'h04;
	localparam logic [7:0] OFS_PLL_R = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;

	// Serial port register addresses (low seven address bits)
	localparam logic [6:0] SPI_ADR_N_HI = 7'h40;
	localparam logic [6:0] SPI_ADR_N_LO = 7'h41;
	localparam logic [6:0] SPI_ADR_R = 7'h42;
	localparam logic [6:0] SPI_ADR_CONFIG = 7'h43;

	// Strap dependent divider defaults: low strap 16.368 MHz, high 19.2 MHz
	localparam logic [11:0] NDIV_DEF_LO = 12'h060;
	localparam logic [11:0] NDIV_DEF_HI = 12'h613;
	localparam logic [5:0] RDIV_DEF_LO = 6'h01;
	localparam logic [5:0] RDIV_DEF_HI = 6'h13;
	localparam logic SLEW_FAST_DEF = 1'b0;

	// Bus write responses
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Configuration word, bit 0 is ref_19m2
	typedef struct packed {
		logic bb_src_vco;
		logic slew_fast;
		logic ref_19m2;
	} cfg_t;

	// Enables for the analog sections and the two clock drivers
	typedef struct packed {
		logic standby;
		logic osc_en;
		logic receiver_chain_enable;
		logic synth_en;
		logic ref_clk_en;
		logic bb_clk_en;
	} power_t;

	// Status word, bit 0 is override
	typedef struct packed {
		logic chip_en;
		logic rx_en;
		logic strap;
		logic mode_eff;
		logic override;
	} status_t;

endpackage

/* verilog/bb_clock_div.sv */
/*
 * Divides a stream of VCO edge pulses down to a square wave.
 * Assumes edge_i is a one-cycle pulse per VCO rising edge, in clock_i.
 */
`timescale 1ns/100ps
`default_nettype none

module bb_clock_div #(
	parameter int unsigned DIVIDE = rf_pwr_pkg::VCO_DIVIDE
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// Edge stream in, divided clock out
	input wire logic edge_i,
	output logic div_o
);
	import rf_pwr_pkg::*;

	localparam int unsigned HALF = DIVIDE / 2;
	localparam logic [7:0] HALF_LAST = 8'(HALF - 1);

	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic div_q;
	wire wrap = edge_i && (cnt_q == HALF_LAST);

	// Even divide toggled every half count keeps the duty at one half
	assign cnt_d = wrap ? 8'h00 : (edge_i ? 8'(cnt_q + 8'h01) : cnt_q); // RQ11

	// Toggle once per half period of the divided clock
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			cnt_q <= 8'h00;
			div_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			div_q <= wrap ? ~div_q : div_q; // RQ1
		end
	end

	assign div_o = div_q;

endmodule

`default_nettype wire

/* verilog/serial_port.sv */
/*
 * Four-wire serial slave: one address byte then one data byte, MSB first.
 * Address bit 7 high writes, low reads. Assumes the serial pins are
 * synchronous to clock_i and each serial clock phase lasts two or more
 * system clocks.
 */
`timescale 1ns/100ps
`default_nettype none

module serial_port (
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// Serial pins
	input wire logic serial_clk_i,
	input wire logic serial_cs_n_i,
	input wire logic serial_data_in_i,
	output logic serial_data_out_o,
	// Register side
	output logic [6:0] addr_o,
	input wire logic [7:0] rd_data_i,
	output logic wr_o,
	output logic [7:0] wr_data_o
);
	import rf_pwr_pkg::*;

	logic sclk_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q;
	logic [7:0] addr_q;
	logic [7:0] out_q;
	logic load_q;
	logic sdo_q;
	logic wr_q;
	wire rise = serial_clk_i && !sclk_q;
	wire fall = !serial_clk_i && sclk_q;
	wire [7:0] sh_next = {sh_q[6:0], serial_data_in_i};

	// Shift in on rising, shift out on falling; chip select low frames it
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			sclk_q <= 1'b0;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			addr_q <= 8'h00;
			out_q <= 8'h00;
			load_q <= 1'b0;
			sdo_q <= 1'b0;
			wr_q <= 1'b0;
		end else begin
			sclk_q <= serial_clk_i;
			load_q <= 1'b0;
			wr_q <= 1'b0;
			if (serial_cs_n_i) begin // RQ4
				cnt_q <= 4'h0;
				sdo_q <= 1'b0;
			end else if (rise) begin
				sh_q <= sh_next;
				cnt_q <= 4'(cnt_q + 4'h1);
				if (cnt_q == 4'h7) begin
					addr_q <= sh_next;
					load_q <= 1'b1;
				end
				wr_q <= (cnt_q == 4'hF) && addr_q[7];
			end else if (fall && cnt_q[3]) begin
				sdo_q <= out_q[7];
				out_q <= {out_q[6:0], 1'b0};
			end
			if (load_q) begin
				out_q <= rd_data_i;
			end
		end
	end

	assign serial_data_out_o = sdo_q;
	assign addr_o = addr_q[6:0];
	assign wr_o = wr_q;
	assign wr_data_o = sh_q;

endmodule

`default_nettype wire

/* verilog/rf_frontend_power_clock_ctrl.sv */
/*
 * Power mode and output clock control of an RF front end, with its
 * configuration registers reached over AXI4-Lite and the serial port.
 * Assumes all pin inputs, including the crystal and VCO taps, are
 * synchronous to clock_i and slower than half its rate.
 */
// Summary of operation
// RQ1: Baseband clock comes from the crystal or from the VCO divided by 96.
// RQ2: Baseband clock is nominally 16.368 MHz.
// RQ3: Output slew rate is a software writable setting.
// RQ4: Serial port has data in, data out, clock and active-low select.
// RQ5: Chip enable low means standby with everything off.
// RQ6: Clock-only mode runs oscillator and one clock output chosen by strap.
// RQ7: Both enables high turns on every block; the code keeps the reference clock off for strap 0.
// RQ8: In full operation the reference clock output stops only for strap 0.
// RQ9: Chip enable rising edge resets all serial registers to defaults.
// RQ10: Strap rules until software writes; then writes hold until next reset.
// RQ11: Baseband clock has a fifty percent duty cycle.
// RQ12: Strap low loads 16.368 MHz defaults, high loads 19.2 MHz defaults.
// RQ13: Receiver chain enable low keeps RF and synthesizer off.
// RQ14: Mode decode is combinational on both enables and the strap; the code flops the decoded enables, so power_o follows one clock later.
`timescale 1ns/100ps
`default_nettype none

module rf_frontend_power_clock_ctrl #(
	parameter int unsigned DIVIDE = rf_pwr_pkg::VCO_DIVIDE,
	parameter int unsigned ADDR_W = 8
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// Control pins
	input wire logic chip_enable_i,
	input wire logic receiver_chain_enable_i,
	input wire logic mode_strap_i,
	// Clock sources and sample bits from the analog side
	input wire logic xtal_i,
	input wire logic vco_i,
	input wire logic sample_sign_i,
	input wire logic sample_mag_i,
	// Clock and sample outputs
	output logic baseband_clock_out_o,
	output logic ref_clock_out_o,
	output logic sign_bit_out_o,
	output logic magnitude_bit_out_o,
	// Analog enables and settings
	output rf_pwr_pkg::power_t power_o,
	output logic slew_fast_o,
	output logic [11:0] pll_n_o,
	output logic [5:0] pll_r_o,
	// Serial port
	input wire logic serial_clk_i,
	input wire logic serial_cs_n_i,
	input wire logic serial_data_in_i,
	output logic serial_data_out_o,
	// AXI4-Lite write channels
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import rf_pwr_pkg::*;

	// Merge one byte into a field under its byte strobe
	function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] val,
			input logic en);
		merge8 = en ? val : old;
	endfunction

	// Configuration registers
	cfg_t cfg_q;
	cfg_t cfg_d;
	logic override_q;
	logic override_d;
	logic [11:0] ndiv_q;
	logic [11:0] ndiv_d;
	logic [5:0] rdiv_q;
	logic [5:0] rdiv_d;

	// Pin history and registered outputs
	logic chip_en_q;
	logic xtal_q;
	logic vco_q;
	power_t power_q;
	logic bb_clk_q;
	logic ref_clk_q;
	logic sign_q;
	logic mag_q;

	// Bus slave state
	logic aw_rdy_q;
	logic w_rdy_q;
	logic have_aw_q;
	logic have_w_q;
	logic [ADDR_W-1:0] waddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic ar_rdy_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	// Serial port register side
	logic [6:0] spi_addr;
	logic [7:0] spi_rd_data;
	logic spi_wr;
	logic [7:0] spi_wr_data;
	logic vco_div;

	// Rising chip enable clears the register file like a reset
	wire ce_rise = chip_enable_i && !chip_en_q;
	wire reg_reset = reset_i || ce_rise; // RQ9

	// Effective strap: pin until software overrides it
	wire mode_eff = override_q ? cfg_q.ref_19m2 : mode_strap_i; // RQ10

	// Mode decode straight from the pins; outputs are flopped below
	wire chip_on = chip_enable_i; // RQ14
	wire full_on = chip_enable_i && receiver_chain_enable_i; // RQ7
	power_t power_d;
	assign power_d.standby = !chip_on; // RQ5
	assign power_d.osc_en = chip_on; // RQ6
	assign power_d.receiver_chain_enable = full_on; // RQ13
	assign power_d.synth_en = full_on; // RQ13
	// Reference clock runs in both modes only with strap 1
	assign power_d.ref_clk_en = chip_on && mode_eff; // RQ6 RQ8
	// Baseband clock runs in full mode, or in clock-only mode with strap 0
	assign power_d.bb_clk_en = full_on || (chip_on && !mode_eff); // RQ6

	// VCO edges only count while the synthesizer is powered
	wire vco_edge = vco_i && !vco_q && full_on;
	// Crystal path passes at its own rate; VCO path is divided to 16.368 MHz
	wire bb_src = cfg_q.bb_src_vco ? vco_div : xtal_q; // RQ1 RQ2

	// Bus decode
	wire aw_take = s_axi_awvalid && aw_rdy_q;
	wire w_take = s_axi_wvalid && w_rdy_q;
	wire do_write = have_aw_q && have_w_q && !bvalid_q;
	wire b_done = bvalid_q && s_axi_bready;
	wire ar_take = s_axi_arvalid && ar_rdy_q;
	wire r_done = rvalid_q && s_axi_rready;
	wire wr_cfg = do_write && (waddr_q == ADDR_W'(OFS_CONFIG));
	wire wr_n = do_write && (waddr_q == ADDR_W'(OFS_PLL_N));
	wire wr_r = do_write && (waddr_q == ADDR_W'(OFS_PLL_R));
	wire wr_hit = wr_cfg || wr_n || wr_r || (waddr_q == ADDR_W'(OFS_STATUS));

	// Serial decode
	wire sp_n_hi = spi_wr && (spi_addr == SPI_ADR_N_HI);
	wire sp_n_lo = spi_wr && (spi_addr == SPI_ADR_N_LO);
	wire sp_r = spi_wr && (spi_addr == SPI_ADR_R);
	wire sp_cfg = spi_wr && (spi_addr == SPI_ADR_CONFIG);

	// Read words
	status_t status;
	assign status.chip_en = chip_enable_i;
	assign status.rx_en = receiver_chain_enable_i;
	assign status.strap = mode_strap_i;
	assign status.mode_eff = mode_eff;
	assign status.override = override_q;
	wire [31:0] rd_cfg = {29'h0000_0000, cfg_q};
	wire [31:0] rd_n = {20'h0_0000, ndiv_q};
	wire [31:0] rd_r = {26'h000_0000, rdiv_q};
	wire [31:0] rd_st = {27'h000_0000, status};
	wire rd_hit = (s_axi_araddr == ADDR_W'(OFS_CONFIG)) || (s_axi_araddr == ADDR_W'(OFS_PLL_N))
		|| (s_axi_araddr == ADDR_W'(OFS_PLL_R)) || (s_axi_araddr == ADDR_W'(OFS_STATUS));
	wire [31:0] rd_word =
		(s_axi_araddr == ADDR_W'(OFS_CONFIG)) ? rd_cfg :
		(s_axi_araddr == ADDR_W'(OFS_PLL_N)) ? rd_n :
		(s_axi_araddr == ADDR_W'(OFS_PLL_R)) ? rd_r :
		(s_axi_araddr == ADDR_W'(OFS_STATUS)) ? rd_st : 32'h0000_0000;
	assign spi_rd_data =
		(spi_addr == SPI_ADR_N_HI) ? {4'h0, ndiv_q[11:8]} :
		(spi_addr == SPI_ADR_N_LO) ? ndiv_q[7:0] :
		(spi_addr == SPI_ADR_R) ? {2'b00, rdiv_q} :
		(spi_addr == SPI_ADR_CONFIG) ? {5'b00000, cfg_q} : 8'h00;

	// Next register values; serial write first, bus write applied over it
	// Both landing on one field in the same cycle is rare; the bus keeps it
	always_comb begin
		cfg_d = cfg_q;
		ndiv_d = ndiv_q;
		rdiv_d = rdiv_q;
		override_d = override_q;
		if (sp_n_hi) begin
			ndiv_d[11:8] = spi_wr_data[3:0];
		end
		if (sp_n_lo) begin
			ndiv_d[7:0] = spi_wr_data;
		end
		if (sp_r) begin
			rdiv_d = spi_wr_data[5:0];
		end
		if (sp_cfg) begin
			cfg_d = cfg_t'(spi_wr_data[2:0]); // RQ3
			override_d = 1'b1; // RQ10
		end
		if (wr_n) begin
			ndiv_d[7:0] = merge8(ndiv_q[7:0], wdata_q[7:0], wstrb_q[0]);
			ndiv_d[11:8] = wstrb_q[1] ? wdata_q[11:8] : ndiv_d[11:8];
		end
		if (wr_r && wstrb_q[0]) begin
			rdiv_d = wdata_q[5:0];
		end
		if (wr_cfg && wstrb_q[0]) begin
			cfg_d = cfg_t'(wdata_q[2:0]); // RQ3
			override_d = 1'b1; // RQ10
		end
	end

	// Register file, strap picks the defaults on every reset
	always_ff @(posedge clock_i) begin
		if (reg_reset) begin
			ndiv_q <= mode_strap_i ? NDIV_DEF_HI : NDIV_DEF_LO; // RQ12
			rdiv_q <= mode_strap_i ? RDIV_DEF_HI : RDIV_DEF_LO; // RQ12
			cfg_q.ref_19m2 <= mode_strap_i; // RQ12
			cfg_q.bb_src_vco <= mode_strap_i; // RQ1
			cfg_q.slew_fast <= SLEW_FAST_DEF;
			override_q <= 1'b0; // RQ9
		end else begin
			ndiv_q <= ndiv_d;
			rdiv_q <= rdiv_d;
			cfg_q <= cfg_d;
			override_q <= override_d;
		end
	end

	// Pin history for edge detection and the crystal path
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			chip_en_q <= 1'b0;
			xtal_q <= 1'b0;
			vco_q <= 1'b0;
		end else begin
			chip_en_q <= chip_enable_i;
			xtal_q <= xtal_i;
			vco_q <= vco_i;
		end
	end

	// Output drivers held low while disabled
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			power_q <= '0;
			bb_clk_q <= 1'b0;
			ref_clk_q <= 1'b0;
			sign_q <= 1'b0;
			mag_q <= 1'b0;
		end else begin
			power_q <= power_d;
			bb_clk_q <= power_d.bb_clk_en && bb_src; // RQ1
			ref_clk_q <= power_d.ref_clk_en && xtal_q; // RQ8
			sign_q <= full_on && sample_sign_i;
			mag_q <= full_on && sample_mag_i;
		end
	end

	// Write channels: address and data taken in either order
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			aw_rdy_q <= 1'b1;
			w_rdy_q <= 1'b1;
			have_aw_q <= 1'b0;
			have_w_q <= 1'b0;
			waddr_q <= '0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_rdy_q <= 1'b0;
				have_aw_q <= 1'b1;
				waddr_q <= s_axi_awaddr;
			end
			if (w_take) begin
				w_rdy_q <= 1'b0;
				have_w_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				have_aw_q <= 1'b0;
				have_w_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			if (b_done) begin
				bvalid_q <= 1'b0;
				aw_rdy_q <= 1'b1;
				w_rdy_q <= 1'b1;
			end
		end
	end

	// Read channels: one read at a time, answered the cycle after address
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			ar_rdy_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OKAY;
		end else if (ar_take) begin
			ar_rdy_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (r_done) begin
			ar_rdy_q <= 1'b1;
			rvalid_q <= 1'b0;
		end
	end

	// Serial port slave; its registers are the ones above
	serial_port u_serial (
		.clock_i(clock_i),
		.reset_i(reg_reset),
		.serial_clk_i(serial_clk_i),
		.serial_cs_n_i(serial_cs_n_i),
		.serial_data_in_i(serial_data_in_i),
		.serial_data_out_o(serial_data_out_o),
		.addr_o(spi_addr),
		.rd_data_i(spi_rd_data),
		.wr_o(spi_wr),
		.wr_data_o(spi_wr_data)
	);

	// VCO divider for the baseband clock
	bb_clock_div #(
		.DIVIDE(DIVIDE)
	) u_div (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.edge_i(vco_edge),
		.div_o(vco_div)
	);

	// Output assignments, all from flops
	assign baseband_clock_out_o = bb_clk_q;
	assign ref_clock_out_o = ref_clk_q;
	assign sign_bit_out_o = sign_q;
	assign magnitude_bit_out_o = mag_q;
	assign power_o = power_q;
	assign slew_fast_o = cfg_q.slew_fast;
	assign pll_n_o = ndiv_q;
	assign pll_r_o = rdiv_q;
	assign s_axi_awready = aw_rdy_q;
	assign s_axi_wready = w_rdy_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = ar_rdy_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

endmodule

`default_nettype wire

/* dv/rf_pwr_checker.sv */
/*
 * Concurrent checks on the power decode and output gating of the controller.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/100ps
`default_nettype none
module rf_pwr_checker (
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// Pins
	input wire logic chip_enable_i,
	input wire logic receiver_chain_enable_i,
	input wire logic sample_sign_i,
	input wire logic serial_cs_n_i,
	input wire logic sample_mag_i,
	input wire logic xtal_i,
	// Outputs
	input wire rf_pwr_pkg::power_t power_o,
	input wire logic baseband_clock_out_o,
	input wire logic ref_clock_out_o,
	input wire logic sign_bit_out_o,
	input wire logic magnitude_bit_out_o,
	input wire logic serial_data_out_o
);
	import rf_pwr_pkg::*;
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	// Decode flops hold zero for one edge after reset, so look only past that
	sequence live_s; !$past(reset_i); endsequence
	sequence cs_idle_s; serial_cs_n_i [*3]; endsequence
	chk_standby_all_off: assert property (live_s ##0 !$past(chip_enable_i) |-> power_o == 6'h20)
		else $error("standby decode wrong");
	chk_osc_follows_ce: assert property (live_s |-> power_o.osc_en == $past(chip_enable_i)
		&& power_o.standby != power_o.osc_en) else $error("oscillator enable wrong");
	chk_rx_off_rf: assert property (live_s ##0 !$past(receiver_chain_enable_i)
		|-> !power_o.receiver_chain_enable && !power_o.synth_en) else $error("rf on without rx enable");
	chk_full_active: assert property (live_s ##0 $past(chip_enable_i && receiver_chain_enable_i)
		|-> power_o.receiver_chain_enable && power_o.synth_en && power_o.bb_clk_en) else $error("full mode off");
	chk_clk_only_one: assert property (live_s ##0 $past(chip_enable_i && !receiver_chain_enable_i)
		|-> power_o.ref_clk_en != power_o.bb_clk_en) else $error("clock-only output count wrong");
	chk_ref_gated: assert property (live_s ##0 !power_o.ref_clk_en |-> !ref_clock_out_o)
		else $error("reference clock driven while off");
	chk_bb_gated: assert property (live_s ##0 !power_o.bb_clk_en |-> !baseband_clock_out_o)
		else $error("baseband clock driven while off");
	chk_sample_gate: assert property (live_s |-> sign_bit_out_o ==
		$past(sample_sign_i && chip_enable_i && receiver_chain_enable_i)) else $error("sign gate wrong");
	chk_mag_gate: assert property (live_s |-> magnitude_bit_out_o ==
		$past(sample_mag_i && chip_enable_i && receiver_chain_enable_i)) else $error("mag gate wrong");
	// Crystal passes two flops before the pin, so skip two edges after reset
	chk_ref_follows: assert property (!$past(reset_i, 2) ##0 live_s ##0 power_o.ref_clk_en
		|-> ref_clock_out_o == $past(xtal_i, 2)) else $error("reference clock not driven");
	chk_serial_quiet: assert property (cs_idle_s |-> !serial_data_out_o)
		else $error("serial out active while deselected");
endmodule
`default_nettype wire

/* dv/baseband_model.sv */
/*
 * Baseband side of the serial port: frames one address and one data byte.
 * Assumes the controller samples the serial pins in clock_i.
 */
`timescale 1ns/100ps
`default_nettype none
module baseband_model (
	// Clock
	input wire logic clock_i,
	// Serial pins
	input wire logic serial_data_out_i,
	output logic serial_clk_o,
	output logic serial_cs_n_o,
	output logic serial_data_o
);
	// Half period of five keeps margin over the sampled falling-edge delay
	localparam int HALF = 5;
	initial begin
		serial_clk_o = 1'b0;
		serial_cs_n_o = 1'b1;
		serial_data_o = 1'b0;
	end
	// Four-wire frame, MSB first; clock stands still low outside frames
	task automatic frame(input logic [7:0] adr, input logic [7:0] dat, output logic [7:0] rd);
		logic [15:0] bits;
		bits = {adr, dat};
		rd = 8'h00;
		@(posedge clock_i) serial_cs_n_o <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			@(posedge clock_i);
			serial_clk_o <= 1'b0;
			serial_data_o <= bits[i];
			repeat (HALF - 1) @(posedge clock_i);
			@(posedge clock_i);
			if (i < 8) rd = {rd[6:0], serial_data_out_i};
			serial_clk_o <= 1'b1;
			repeat (HALF - 1) @(posedge clock_i);
		end
		@(posedge clock_i);
		serial_clk_o <= 1'b0;
		serial_cs_n_o <= 1'b1;
		serial_data_o <= ~serial_data_o; // Released line must not look valid
		repeat (HALF) @(posedge clock_i);
	endtask
endmodule
`default_nettype wire

/* dv/test_rf_frontend_power_clock_ctrl.sv */
/*
 * Self-checking bench for the power and clock controller.
 * Assumes the package and design files are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module test_rf_frontend_power_clock_ctrl;
	import rf_pwr_pkg::*;
	logic clock_i = 1'b0, reset_i = 1'b1;
	logic chip_enable_i = 1'b0, receiver_chain_enable_i = 1'b0, mode_strap_i = 1'b0;
	logic xtal_i = 1'b0, vco_i = 1'b0, sample_sign_i = 1'b0, sample_mag_i = 1'b0;
	logic baseband_clock_out_o, ref_clock_out_o, sign_bit_out_o, magnitude_bit_out_o;
	power_t power_o;
	logic slew_fast_o, serial_clk_i, serial_cs_n_i, serial_data_in_i, serial_data_out_o;
	logic [11:0] pll_n_o;
	logic [5:0] pll_r_o;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] rdat;
	logic [7:0] sdat;
	logic [2:0] xc = 3'h0;
	int n_errors = 0, samples_checked = 0, hi, lo;

	rf_frontend_power_clock_ctrl #(.DIVIDE(6), .ADDR_W(8)) i_rf_frontend_power_clock_ctrl (
		.clock_i, .reset_i, .chip_enable_i, .receiver_chain_enable_i, .mode_strap_i,
		.xtal_i, .vco_i, .sample_sign_i, .sample_mag_i, .baseband_clock_out_o,
		.ref_clock_out_o, .sign_bit_out_o, .magnitude_bit_out_o, .power_o, .slew_fast_o,
		.pll_n_o, .pll_r_o, .serial_clk_i, .serial_cs_n_i, .serial_data_in_i,
		.serial_data_out_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	baseband_model i_baseband_model (.clock_i, .serial_data_out_i(serial_data_out_o),
		.serial_clk_o(serial_clk_i), .serial_cs_n_o(serial_cs_n_i),
		.serial_data_o(serial_data_in_i));

	// Clock at 40 MHz
	always #12.5 clock_i = ~clock_i;
	// Crystal high three, low three; VCO edge every second clock
	always @(posedge clock_i) begin
		xc <= (xc == 3'h5) ? 3'h0 : xc + 3'h1;
		xtal_i <= (xc < 3'h3);
		vco_i <= ~vco_i;
		sample_sign_i <= xc[0];
		sample_mag_i <= xc[1];
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clock_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clock_i);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clock_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clock_i);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// Decode shows one clock after the pins; two edges leave margin
	task automatic set_pins(input logic ce, input logic rx, input logic st);
		@(posedge clock_i);
		chip_enable_i <= ce;
		receiver_chain_enable_i <= rx;
		mode_strap_i <= st;
		repeat (2) @(posedge clock_i);
	endtask
	function automatic logic [5:0] exp_pwr(input logic ce, input logic rx, input logic st);
		return {!ce, ce, ce & rx, ce & rx, ce & st, (ce & rx) | (ce & !st)};
	endfunction
	task automatic run_len(output int h, output int l);
		h = 0;
		l = 0;
		while (baseband_clock_out_o !== 1'b0) @(posedge clock_i);
		while (baseband_clock_out_o !== 1'b1) @(posedge clock_i);
		while (baseband_clock_out_o === 1'b1) begin
			h++;
			@(posedge clock_i);
		end
		while (baseband_clock_out_o === 1'b0) begin
			l++;
			@(posedge clock_i);
		end
	endtask

	task automatic t_defaults;
		set_pins(0, 1, 0);
		set_pins(1, 1, 0);
		axi_rd(OFS_PLL_N, rdat, rsp);
		check(rdat, 32'h0000_0060);
		axi_rd(OFS_PLL_R, rdat, rsp);
		check(rdat, 32'h0000_0001);
		check(rsp, 2'b00);
		set_pins(0, 1, 1);
		set_pins(1, 1, 1);
		axi_rd(OFS_PLL_N, rdat, rsp);
		check(rdat, 32'h0000_0613);
		axi_rd(OFS_CONFIG, rdat, rsp);
		check(rdat, 32'h0000_0005);
		check(pll_r_o, 6'h13);
		$display("defaults test done");
	endtask
	task automatic t_modes;
		for (int i = 0; i < 8; i++) begin
			set_pins(i[2], i[1], i[0]);
			check(power_o, exp_pwr(i[2], i[1], i[0]));
			axi_rd(OFS_STATUS, rdat, rsp);
			check(rdat, {27'h000_0000, i[2], i[1], i[0], i[0], 1'b0});
		end
		$display("modes test done");
	endtask
	task automatic t_override;
		set_pins(0, 0, 1);
		set_pins(1, 0, 1);
		check(power_o, 6'h12);
		i_baseband_model.frame(8'hC3, 8'h02, sdat);
		set_pins(1, 0, 0);
		set_pins(1, 0, 1);
		check(power_o, 6'h11);
		check(slew_fast_o, 1'b1);
		i_baseband_model.frame(8'h43, 8'h00, sdat);
		check(sdat, 8'h02);
		axi_wr(OFS_CONFIG, 32'h0000_0005, rsp);
		check(rsp, 2'b00);
		check(slew_fast_o, 1'b0);
		// Power decode is registered, so it trails the config write by one clock
		@(posedge clock_i);
		check(power_o, 6'h12);
		i_baseband_model.frame(8'hC0, 8'h07, sdat);
		i_baseband_model.frame(8'hC1, 8'h89, sdat);
		check(pll_n_o, 12'h789);
		set_pins(0, 0, 0);
		set_pins(1, 0, 0);
		check(pll_n_o, 12'h060);
		axi_rd(OFS_CONFIG, rdat, rsp);
		check(rdat, 32'h0000_0000);
		check(power_o, 6'h11);
		$display("override test done");
	endtask
	task automatic t_bus;
		axi_wr(8'h10, 32'h0000_0001, rsp);
		check(rsp, 2'b10);
		axi_rd(8'h10, rdat, rsp);
		check(rdat, 32'h0000_0000);
		check(rsp, 2'b10);
		axi_wr(OFS_PLL_R, 32'h0000_003F, rsp);
		check(pll_r_o, 6'h3F);
		// Low byte strobe only: N bits 11:8 keep the strap default
		s_axi_wstrb <= 4'h1;
		axi_wr(OFS_PLL_N, 32'h0000_0ABC, rsp);
		s_axi_wstrb <= 4'hF;
		check(pll_n_o, 12'h0BC);
		$display("bus test done");
	endtask
	task automatic t_bbclk;
		set_pins(0, 1, 0);
		set_pins(1, 1, 0);
		run_len(hi, lo);
		check(hi, 3);
		check(lo, 3);
		set_pins(0, 1, 1);
		set_pins(1, 1, 1);
		run_len(hi, lo);
		check(hi, 6);
		check(lo, 6);
		$display("baseband clock test done");
	endtask

	task automatic stop_test;
		$display("checks %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Main sequence after twenty cycles of reset
	initial begin
		repeat (20) @(posedge clock_i);
		reset_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		t_defaults();
		t_modes();
		t_override();
		t_bus();
		t_bbclk();
		stop_test();
	end
	// Watchdog well beyond the thousand or so cycles the tests need
	initial begin
		#500000;
		n_errors++;
		stop_test();
	end
endmodule
bind rf_frontend_power_clock_ctrl rf_pwr_checker i_rf_pwr_checker (.clock_i(clock_i),
	.reset_i(reset_i), .chip_enable_i(chip_enable_i),
	.receiver_chain_enable_i(receiver_chain_enable_i), .sample_sign_i(sample_sign_i),
	.serial_cs_n_i(serial_cs_n_i), .power_o(power_o),
	.baseband_clock_out_o(baseband_clock_out_o), .ref_clock_out_o(ref_clock_out_o),
	.sign_bit_out_o(sign_bit_out_o), .serial_data_out_o(serial_data_out_o),
	.sample_mag_i(sample_mag_i), .xtal_i(xtal_i), .magnitude_bit_out_o(magnitude_bit_out_o));
`default_nettype wire
